// ===== stp_consts.svh
// constants for the stepper serial setting latch
// ----------------------------------------------------------------
// Functional notes
// - a setting frame is exactly sixteen bits
// - bit 0 goes first, bit 15 last
// - data captured on falling serial clock edge
// - shift register advances on rising serial edge
// - strobe rising edge copies all sixteen bits
// - reset clears shifter, outputs off, pump halted
// - two torque bits pick one of four ratios
// - two decay bits per winding pick mode
// - four current bits and polarity per winding
// ----------------------------------------------------------------
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// frame geometry
`define STP_FRAME_BITS   16
`define STP_TORQUE_LSB   0
`define STP_DECAY_B_LSB  2
`define STP_CURR_B_LSB   4
`define STP_POL_B_BIT    8
`define STP_DECAY_A_LSB  9
`define STP_CURR_A_LSB   11
`define STP_POL_A_BIT    15

// comparator reference ratios in percent
`define STP_RATIO_100    7'h64
`define STP_RATIO_85     7'h55
`define STP_RATIO_70     7'h46
`define STP_RATIO_50     7'h32

// register byte offsets
`define STP_OFS_CTRL     8'h00
`define STP_OFS_LATCH    8'h04
`define STP_OFS_STATUS   8'h08
`define STP_OFS_SHIFT    8'h0c

// control fields and reset value
`define STP_CTRL_OUT_BIT  0
`define STP_CTRL_PUMP_BIT 1
`define STP_CTRL_RESET    2'h3

// status fields
`define STP_STAT_RST_BIT  0
`define STP_STAT_CNT_LSB  8

`endif

// ===== stp_pkg.sv
// types shared by the stepper serial latch modules
`default_nettype none
package stp_pkg;
	// decay selection, x1 is the upper bit
	typedef enum logic [1:0] {
		STP_DECAY_SLOW   = 2'h0,
		STP_DECAY_MIX_LO = 2'h1,
		STP_DECAY_MIX_HI = 2'h2,
		STP_DECAY_FAST   = 2'h3
	} stp_decay_type;
endpackage
`default_nettype wire

// ===== stp_link_if.sv
// carrier from the serial shifter to the register core
`default_nettype none
interface stp_link_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] word;   // live shift register contents
	modport src (output word);
	modport dst (input word);
endinterface
`default_nettype wire

// ===== stp_sync.sv
// two flip-flop level synchroniser into the destination clock
`default_nettype none
module stp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ===== stp_shift.sv
// serial shifter running on the host serial clock
`default_nettype none
`include "stp_consts.svh"
module stp_shift
	import stp_pkg::*;
#(
	parameter int WIDTH = `STP_FRAME_BITS
) (
	// link clock and reset
	input  wire logic sclk,
	input  wire logic link_rst_n,
	// serial data, synchronous to sclk
	input  wire logic sdata,
	// word towards the core
	stp_link_if.src   link
);
	logic             cap_ff;
	logic [WIDTH-1:0] shift_ff;

	// sample the data line on the falling edge
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cap_ff <= 1'b0;
		end else begin
			cap_ff <= sdata;
		end
	end

	// new bit enters at the top, so the first bit ends in bit 0
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_ff <= '0;
		end else begin
			shift_ff <= {cap_ff, shift_ff[WIDTH-1:1]};
		end
	end

	assign link.word = shift_ff;

	capture_edge_a: assert property (
		@(negedge sclk) disable iff (!link_rst_n) 1'b1 |=> cap_ff == $past(sdata))
		else $error("falling edge did not capture the data line");

	shift_move_a: assert property (
		@(posedge sclk) disable iff (!link_rst_n)
		1'b1 |=> shift_ff == {$past(cap_ff), $past(shift_ff[WIDTH-1:1])})
		else $error("shift register did not advance by one");
endmodule
`default_nettype wire

// ===== stp_serial_latch.sv
// stepper serial setting latch with its register slave
`default_nettype none
`include "stp_consts.svh"
module stp_serial_latch
	import stp_pkg::*;
#(
	parameter int WIDTH = `STP_FRAME_BITS
) (
	// system clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// register bus
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	// serial link pins
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        strobe,
	input  wire logic        drv_reset_n,
	// motor settings
	output var  logic [6:0]  ratio_pct,
	output var  logic [1:0]  decay_a,
	output var  logic [1:0]  decay_b,
	output var  logic [3:0]  current_a,
	output var  logic [3:0]  current_b,
	output var  logic        polarity_a,
	output var  logic        polarity_b,
	output var  logic        outputs_on,
	output var  logic        pump_on
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic             link_rst_n;
	logic [WIDTH-1:0] word_sync;
	logic [1:0]       pins_sync;
	logic             strobe_s;
	logic             shift_clear;
	logic             strobe_d_ff;
	logic             strobe_rise;
	logic [WIDTH-1:0] latch_ff;
	logic [7:0]       frames_ff;
	logic [1:0]       ctrl_ff;
	logic             dp_wr_ff;
	logic [7:0]       dp_addr_ff;
	logic             ap_take;

	stp_link_if #(.WIDTH(WIDTH)) link ();

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	// the serial clock may stop at any time, so the pin reset clears
	// the shifter asynchronously rather than waiting for an edge
	assign link_rst_n = hresetn & drv_reset_n;

	stp_shift #(.WIDTH(WIDTH)) u_shift (
		.sclk       (sclk),
		.link_rst_n (link_rst_n),
		.sdata      (sdata),
		.link       (link.src)
	);

	// the word is quiet once the host has stopped clocking, and the
	// strobe sync path has the same two stages, so the word settles first
	stp_sync #(.WIDTH(WIDTH)) u_word_sync (
		.clk      (hclk),
		.rst_n    (hresetn),
		.async_in (link.word),
		.sync_out (word_sync)
	);

	// strobe and reset pin into the system clock; the pin goes in at
	// its own level so that the zero reset of the sync reads as pin
	// reset held, keeping the bridges off until the pin is seen high
	stp_sync #(.WIDTH(2)) u_pin_sync (
		.clk      (hclk),
		.rst_n    (hresetn),
		.async_in ({strobe, drv_reset_n}),
		.sync_out (pins_sync)
	);

	assign strobe_s    = pins_sync[1];
	assign shift_clear = ~pins_sync[0];

	// ----------------------------------------------------------------
	// strobe edge and setting latch
	// ----------------------------------------------------------------
	// edge detector reads only the second sync stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strobe_d_ff <= 1'b0;
		end else begin
			strobe_d_ff <= strobe_s;
		end
	end

	assign strobe_rise = strobe_s & ~strobe_d_ff;

	// whole frame copied at once; cleared while the pin reset is seen, held otherwise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_ff <= '0;
		end else if (shift_clear) begin
			latch_ff <= '0;
		end else if (strobe_rise) begin
			latch_ff <= word_sync;
		end
	end

	// frame counter for software, wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frames_ff <= 8'h00;
		end else if (shift_clear) begin
			frames_ff <= 8'h00;
		end else if (strobe_rise) begin
			frames_ff <= frames_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// setting decode
	// ----------------------------------------------------------------
	// torque0 is the low bit, torque1 the high bit
	function automatic logic [6:0] ratio_of(input logic [1:0] tq);
		logic [6:0] r;
		r = `STP_RATIO_50;
		unique case (tq)
			2'b11: r = `STP_RATIO_100;
			2'b10: r = `STP_RATIO_85;
			2'b01: r = `STP_RATIO_70;
			2'b00: r = `STP_RATIO_50;
		endcase
		return r;
	endfunction

	// outputs follow the latch one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ratio_pct  <= `STP_RATIO_50;
			decay_a    <= STP_DECAY_SLOW;
			decay_b    <= STP_DECAY_SLOW;
			current_a  <= 4'h0;
			current_b  <= 4'h0;
			polarity_a <= 1'b0;
			polarity_b <= 1'b0;
		end else begin
			ratio_pct  <= ratio_of(latch_ff[`STP_TORQUE_LSB +: 2]);
			decay_a    <= latch_ff[`STP_DECAY_A_LSB +: 2];
			decay_b    <= latch_ff[`STP_DECAY_B_LSB +: 2];
			current_a  <= latch_ff[`STP_CURR_A_LSB +: 4];
			current_b  <= latch_ff[`STP_CURR_B_LSB +: 4];
			polarity_a <= latch_ff[`STP_POL_A_BIT];
			polarity_b <= latch_ff[`STP_POL_B_BIT];
		end
	end

	// bridge and pump enables: pin reset wins over software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			outputs_on <= 1'b0;
			pump_on    <= 1'b0;
		end else begin
			outputs_on <= ~shift_clear & ctrl_ff[`STP_CTRL_OUT_BIT];
			pump_on    <= ~shift_clear & ctrl_ff[`STP_CTRL_PUMP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	assign ap_take = hsel & htrans[1] & hready;

	// register read mux; a write still in its data phase is forwarded
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			`STP_OFS_CTRL: begin
				if (dp_wr_ff && dp_addr_ff == `STP_OFS_CTRL) begin
					d[1:0] = hwdata[1:0];
				end else begin
					d[1:0] = ctrl_ff;
				end
			end
			`STP_OFS_LATCH:  d[WIDTH-1:0] = latch_ff;
			`STP_OFS_STATUS: begin
				d[`STP_STAT_RST_BIT] = shift_clear;
				d[`STP_STAT_CNT_LSB +: 8] = frames_ff;
			end
			`STP_OFS_SHIFT:  d[WIDTH-1:0] = word_sync;
			default:         d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	// address phase capture; only whole-word singles are expected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_ff   <= 1'b0;
			dp_addr_ff <= 8'h00;
		end else begin
			dp_wr_ff   <= ap_take & hwrite;
			dp_addr_ff <= {haddr[7:2], 2'b00};
		end
	end

	// read data is ready for the data phase that follows
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hrdata <= reg_read({haddr[7:2], 2'b00});
		end
	end

	// the slave never stalls and never errors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// control register write in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= `STP_CTRL_RESET;
		end else if (dp_wr_ff && dp_addr_ff == `STP_OFS_CTRL) begin
			ctrl_ff <= hwdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	latch_copy_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		strobe_rise && !shift_clear |=> latch_ff == $past(word_sync))
		else $error("strobe rise did not copy the frame");

	latch_hold_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!strobe_rise && !shift_clear |=> $stable(latch_ff))
		else $error("latch changed without a strobe rise");

	ratio_map_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		latch_ff[1:0] == 2'b10 |=> ratio_pct == `STP_RATIO_85)
		else $error("torque code did not select its ratio");

	decay_map_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> decay_a == $past(latch_ff[`STP_DECAY_A_LSB +: 2])
		&& decay_b == $past(latch_ff[`STP_DECAY_B_LSB +: 2]))
		else $error("decay selection does not follow the latch");

	current_map_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> current_a == $past(latch_ff[`STP_CURR_A_LSB +: 4])
		&& polarity_b == $past(latch_ff[`STP_POL_B_BIT]))
		else $error("current or polarity does not follow the latch");

	frame_order_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		strobe_rise && !shift_clear |-> ##2 polarity_a == $past(word_sync[WIDTH-1], 2))
		else $error("last serial bit did not become the polarity");

	reset_off_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		shift_clear |=> !outputs_on && !pump_on && latch_ff == '0)
		else $error("reset pin left outputs or pump running");

	enable_follow_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!shift_clear |=> outputs_on == $past(ctrl_ff[`STP_CTRL_OUT_BIT])
		&& pump_on == $past(ctrl_ff[`STP_CTRL_PUMP_BIT]))
		else $error("enables do not follow the control bits");

	ratio_full_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		latch_ff[1:0] == 2'b11 |=> ratio_pct == `STP_RATIO_100)
		else $error("full torque code did not select its ratio");

	ratio_mid_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		latch_ff[1:0] == 2'b01 |=> ratio_pct == `STP_RATIO_70)
		else $error("low torque bit did not select its ratio");

	ratio_min_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		latch_ff[1:0] == 2'b00 |=> ratio_pct == `STP_RATIO_50)
		else $error("zero torque code did not select its ratio");

	winding_b_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> current_b == $past(latch_ff[`STP_CURR_B_LSB +: 4])
		&& polarity_a == $past(latch_ff[`STP_POL_A_BIT]))
		else $error("second current or first polarity does not follow the latch");

	frame_count_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		strobe_rise && !shift_clear |=> frames_ff == $past(frames_ff) + 8'h01)
		else $error("strobe rise was not counted as a frame");

	bus_ready_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ap_take |=> hreadyout && !hresp)
		else $error("slave stalled or errored");
endmodule
`default_nettype wire

// ===== stp_host_model.sv
// behavioural host that shifts setting frames into the device
`default_nettype none
module stp_host_model (
	// serial pins toward the device
	output var logic sclk,
	output var logic sdata,
	output var logic strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// serial clock idles high and stands still between frames
	initial begin
		sclk   = 1'b1;
		sdata  = 1'b0;
		strobe = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame transfer
	// ----------------------------------------------------------------
	// one frame, lowest bit first; data moves only while sclk is high
	task automatic send(input logic [15:0] w);
		#3;
		for (int i = 0; i < 16; i++) begin
			sdata = w[i];
			#8 sclk = 1'b0;
			#16 sclk = 1'b1;
			#8;
		end
		sdata = ~w[15]; // a released line must not mimic the last bit
	endtask

	// strobe rises only after the whole frame, with margin for the sync
	task automatic pulse();
		#43 strobe = 1'b1; // kept off the system clock edge
		#40 strobe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== stp_serial_latch_tb_top.sv
// self-checking bench for the stepper serial setting latch
`default_nettype none
module stp_serial_latch_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk, hresetn, hsel, hwrite, drv_reset_n;
	logic        sclk, sdata, strobe, hreadyout, hresp;
	logic        polarity_a, polarity_b, outputs_on, pump_on;
	logic [1:0]  htrans, decay_a, decay_b;
	logic [2:0]  hsize;
	logic [3:0]  current_a, current_b;
	logic [6:0]  ratio_pct;
	logic [7:0]  haddr;
	logic [15:0] w, w2;
	logic [31:0] hwdata, hrdata, rd;
	int          bad_count, tests_run, frames;

	// system clock, 100 MHz
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// hready is the single slave's own hreadyout
	stp_serial_latch dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .sdata(sdata),
		.strobe(strobe), .drv_reset_n(drv_reset_n), .ratio_pct(ratio_pct), .decay_a(decay_a),
		.decay_b(decay_b), .current_a(current_a), .current_b(current_b),
		.polarity_a(polarity_a), .polarity_b(polarity_b), .outputs_on(outputs_on),
		.pump_on(pump_on));

	stp_host_model host_u (.sclk(sclk), .sdata(sdata), .strobe(strobe));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single AHB-Lite transfer; read data lands in rd
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// ratio that the two torque bits should select
	function automatic logic [31:0] ratio(input logic [1:0] t);
		case (t)
			2'h3: return 32'd100;
			2'h2: return 32'd85;
			2'h1: return 32'd70;
			default: return 32'd50;
		endcase
	endfunction

	// model of the latched word compared against the ratio, decay, current and polarity outputs and the latch register
	task check_out(input logic [15:0] m);
		chk(32'(ratio_pct), ratio(m[1:0]));
		chk(32'({polarity_a, current_a, decay_a}), 32'(m[15:9]));
		chk(32'({polarity_b, current_b, decay_b}), 32'(m[8:2]));
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'(m));
	endtask

	// shift a frame, then look at the synchronised shift word
	task frame(input logic [15:0] m);
		host_u.send(m);
		repeat (4) @(posedge hclk);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'(m));
	endtask

	// strobe and give the sync stages time to land
	task latch();
		host_u.pulse();
		frames++;
		repeat (8) @(posedge hclk);
	endtask

	task end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// a hang ends the run well after the normal span of some 5 us
	initial begin
		#200_000;
		bad_count++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 8'h00;
		hwdata = 32'h0;
		drv_reset_n = 1'b1;
		void'($urandom(56));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		// the pin sync still shows reset at the first two edges
		repeat (2) @(posedge hclk);
		chk(32'({outputs_on, pump_on}), 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'({outputs_on, pump_on, ratio_pct}), 32'h0000_01b2);
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0003);
		chk(32'(hresp), 32'h0);
		$display("test reset_values done");
		// every torque code with random remaining bits
		for (int t = 0; t < 4; t++) begin
			w = (16'($urandom) & 16'hfffc) | 16'(t);
			frame(w);
			latch();
			check_out(w);
		end
		$display("test torque_frames done");
		// settings must hold while the next frame shifts in
		w2 = ~w;
		frame(w2);
		check_out(w);
		latch();
		check_out(w2);
		ahb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'h0000_ff01, 32'(frames) << 8);
		$display("test hold_until_strobe done");
		// control, read-only and unmapped places
		ahb(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge hclk);
		chk(32'({outputs_on, pump_on}), 32'h0);
		ahb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, 8'h00, 32'h0000_0003);
		ahb(1'b1, 8'h04, 32'h0000_ffff);
		ahb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'(w2));
		ahb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		$display("test register_map done");
		// reset pin clears shifter, latch, outputs and pump
		drv_reset_n <= 1'b0;
		repeat (6) @(posedge hclk);
		chk(32'({outputs_on, pump_on, ratio_pct}), 32'h0000_0032);
		ahb(1'b0, 8'h08, 32'h0);
		chk(rd & 32'h0000_ff01, 32'h0000_0001);
		ahb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		drv_reset_n <= 1'b1;
		repeat (6) @(posedge hclk);
		chk(32'({outputs_on, pump_on, ratio_pct}), 32'h0000_01b2);
		$display("test reset_pin done");
		end_of_test();
	end
endmodule
`default_nettype wire
